// file: logic/drs_pkg.sv
// Constants, register map and state type of the device reset sequencer
package drs_pkg;
  // Cause vector bit positions
  localparam int SRC_W = 7;
  localparam int CB_PIN = 0;
  localparam int CB_POWER = 1;
  localparam int CB_CLOCK = 2;
  localparam int CB_WDOG = 3;
  localparam int CB_SOFT = 4;
  localparam int CB_CMP = 5;
  localparam int CB_FLASH = 6;
  // Register offsets (byte addresses)
  localparam int ADDR_W = 5;
  localparam logic [4:0] OFF_CAUSE = 5'h00;
  localparam logic [4:0] OFF_CTRL = 5'h04;
  localparam logic [4:0] OFF_IRQ_STAT = 5'h08;
  localparam logic [4:0] OFF_IRQ_EN = 5'h0C;
  localparam logic [4:0] OFF_IRQ_CLR = 5'h10;
  // Control register fields
  localparam int CTRL_PIN_HOLD = 0;
  localparam int CTRL_CONV_HOLD = 1;
  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] CAUSE_RST = 8'h00;
  localparam logic [7:0] IRQ_EN_RST = 8'h00;
  localparam logic [7:0] IRQ_STAT_RST = 8'h00;
  localparam logic [7:0] PORT_LATCH_RST = 8'hFF;
  localparam logic [15:0] PC_RST = 16'h0000;
  // Release stretch after the last source goes quiet
  localparam int CNT_W = 3;
  localparam logic [2:0] RELEASE_LAST = 3'h3;
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_HOLD = 2'b01,
    ST_RELEASE = 2'b10
  } drs_state_t;
endpackage : drs_pkg

// file: logic/drs_source_merge.sv
// Merges all reset sources into one cause vector
module drs_source_merge (
  input wire logic porActive,
  input wire logic pinLow,
  input wire logic pinSelfDriven,
  input wire logic cmpTrip_n,
  input wire logic cmpResetEn,
  input wire logic supplyLow,
  input wire logic watchdogExpired,
  input wire logic clockMissing,
  input wire logic flashError,
  input wire logic softwareReq,
  output logic [6:0] srcVec,
  output logic anySrc,
  output logic powerClass
);
  always_comb begin
    srcVec = '0;
    // Own pin drive must not count as an external reset
    srcVec[drs_pkg::CB_PIN] = pinLow & ~pinSelfDriven;
    srcVec[drs_pkg::CB_POWER] = porActive | supplyLow;
    srcVec[drs_pkg::CB_CLOCK] = clockMissing;
    srcVec[drs_pkg::CB_WDOG] = watchdogExpired;
    srcVec[drs_pkg::CB_SOFT] = softwareReq;
    srcVec[drs_pkg::CB_CMP] = cmpResetEn & ~cmpTrip_n;
    srcVec[drs_pkg::CB_FLASH] = flashError;
    anySrc = |srcVec;
    powerClass = srcVec[drs_pkg::CB_POWER];
  end
endmodule : drs_source_merge

// file: logic/drs_release_timer.sv
// Counts the release stretch before the core is let go
module drs_release_timer (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  output logic done
);
  logic [2:0] cnt_r;
  logic [2:0] cnt_nxt;

  always_comb begin
    if (start) begin
      cnt_nxt = '0;
    end else if (cnt_r == drs_pkg::RELEASE_LAST) begin
      cnt_nxt = cnt_r;
    end else begin
      cnt_nxt = cnt_r + 3'h1;
    end
    done = (cnt_r == drs_pkg::RELEASE_LAST) & ~start;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_r <= drs_pkg::RELEASE_LAST;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule : drs_release_timer

// file: logic/drs_device_reset_sequencer.sv
// Central reset sequencer with Wishbone registers and interrupt
// Summary of operation
// - Any source halts the core until exit
// - Register bits load reset values, power-only excepted
// - Interrupts and timers disabled during reset
// - Memory kept, stack pointer reloaded
// - Port latches all ones, open-drain, pull-ups on
// - Power and supply resets drive pin low
// - Program counter cleared to zero on exit
// - Watchdog enabled, internal clock selected on exit
// - Converter hold keeps converter through non-power resets
// - Pin hold keeps port state except power-on
// - Eight sources each place device in reset
// - Power-on exit sets power flag, others clear
// - Software write one resets, flag reads one
// - External pin low resets, pin flag set
module drs_device_reset_sequencer (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic resetPinIn_n,
  output logic resetPinOut_n,
  output logic resetPinOe,
  input wire logic cmpTrip_n,
  input wire logic supplyLow,
  input wire logic watchdogExpired,
  input wire logic watchdogDisableReq,
  input wire logic clockMissing,
  input wire logic clockSelExternalReq,
  input wire logic flashError,
  input wire logic [7:0] portLatchCore,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [4:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic coreHalt,
  output logic sfrInit,
  output logic porOnlyInit,
  output logic irqTimersOff,
  output logic stackPtrLoad,
  output logic pcLoad,
  output logic [15:0] pcValue,
  output logic watchdogEnable,
  output logic clockSelInternal,
  output logic [7:0] portLatch,
  output logic portOpenDrain,
  output logic portWeakPullup,
  output logic portStateHold,
  output logic converterHold,
  output logic irq
);
  drs_pkg::drs_state_t state_r, state_nxt;
  logic [6:0] srcVec;
  logic anySrc, powerClass, timerStart, timerDone, exitPulse;
  logic [6:0] latch_r, latch_nxt;
  logic [7:0] cause_r, cause_nxt, ctrl_r, ctrl_nxt;
  logic [7:0] irqStat_r, irqStat_nxt, irqEn_r, irqEn_nxt;
  logic swReq_r, swReq_nxt, ack_r, ack_nxt;
  logic [31:0] dat_r, dat_nxt;
  logic coreHalt_r, coreHalt_nxt, pinOe_r, pinOe_nxt;
  logic porInit_r, stackLoad_r, stackLoad_nxt, pcLoad_r, pcLoad_nxt;
  logic [15:0] pcValue_r;
  logic wdtEn_r, wdtEn_nxt, clkInt_r, clkInt_nxt;
  logic [7:0] port_r, port_nxt;
  logic portHold_r, portHold_nxt, convHold_r, convHold_nxt;
  logic portOd_r, portOd_nxt;
  logic irq_r, irq_nxt;
  logic busReq, busWr;

  drs_source_merge u_merge (
    .porActive(porInit_r),
    .pinLow(~resetPinIn_n),
    .pinSelfDriven(pinOe_r),
    .cmpTrip_n(cmpTrip_n),
    .cmpResetEn(cause_r[drs_pkg::CB_CMP]),
    .supplyLow(supplyLow),
    .watchdogExpired(watchdogExpired),
    .clockMissing(clockMissing),
    .flashError(flashError),
    .softwareReq(swReq_r),
    .srcVec(srcVec),
    .anySrc(anySrc),
    .powerClass(powerClass)
  );

  drs_release_timer u_timer (
    .clk(clk),
    .rst_n(rst_n),
    .start(timerStart),
    .done(timerDone)
  );

  // enter on any source, leave only after stretch
  always_comb begin
    state_nxt = state_r;
    timerStart = 1'b0;
    exitPulse = 1'b0;
    case (state_r)
      drs_pkg::ST_RUN: begin
        if (anySrc) begin
          state_nxt = drs_pkg::ST_HOLD;
        end
      end
      drs_pkg::ST_HOLD: begin
        if (!anySrc) begin
          state_nxt = drs_pkg::ST_RELEASE;
          timerStart = 1'b1;
        end
      end
      drs_pkg::ST_RELEASE: begin
        if (anySrc) begin
          state_nxt = drs_pkg::ST_HOLD;
        end else if (timerDone) begin
          state_nxt = drs_pkg::ST_RUN;
          exitPulse = 1'b1;
        end
      end
      default: begin
        state_nxt = drs_pkg::ST_HOLD;
      end
    endcase
  end

  // Core-facing outputs follow the next state
  always_comb begin
    latch_nxt = (state_r == drs_pkg::ST_RUN) ? srcVec : (latch_r | srcVec);
    // halt while any reset is pending
    coreHalt_nxt = (state_nxt != drs_pkg::ST_RUN);
    // pin low only for power-class causes
    pinOe_nxt = coreHalt_nxt & (latch_nxt[drs_pkg::CB_POWER] | powerClass);
    stackLoad_nxt = exitPulse;
    pcLoad_nxt = exitPulse;
    // watchdog on and internal clock after exit
    wdtEn_nxt = exitPulse | (wdtEn_r & ~watchdogDisableReq);
    clkInt_nxt = exitPulse | (clkInt_r & ~clockSelExternalReq);
    // port state kept when hold bit set
    portHold_nxt = coreHalt_nxt & ctrl_r[drs_pkg::CTRL_PIN_HOLD];
    // converter kept when its hold bit set
    convHold_nxt = coreHalt_nxt & ctrl_r[drs_pkg::CTRL_CONV_HOLD];
    portOd_nxt = coreHalt_nxt & ~portHold_nxt;
    if (coreHalt_nxt && !portHold_nxt) begin
      port_nxt = drs_pkg::PORT_LATCH_RST;
    end else if (coreHalt_nxt) begin
      port_nxt = port_r;
    end else begin
      port_nxt = portLatchCore;
    end
  end

  // Wishbone classic slave, one wait state
  always_comb begin
    busReq = cyc_i & stb_i;
    busWr = busReq & we_i & ack_r & sel_i[0];
    ack_nxt = busReq & ~ack_r;
    dat_nxt = dat_r;
    if (busReq && !ack_r) begin
      case (adr_i)
        drs_pkg::OFF_CAUSE: dat_nxt = {24'h0000_00, cause_r};
        drs_pkg::OFF_CTRL: dat_nxt = {24'h0000_00, ctrl_r};
        drs_pkg::OFF_IRQ_STAT: dat_nxt = {24'h0000_00, irqStat_r};
        drs_pkg::OFF_IRQ_EN: dat_nxt = {24'h0000_00, irqEn_r};
        default: dat_nxt = 32'h0000_0000;
      endcase
    end
    // software write of one requests reset
    swReq_nxt = busWr & (adr_i == drs_pkg::OFF_CAUSE)
      & dat_i[drs_pkg::CB_SOFT] & ~coreHalt_r;
    ctrl_nxt = ctrl_r;
    if (busWr && adr_i == drs_pkg::OFF_CTRL) begin
      ctrl_nxt = {6'h00, dat_i[1:0]};
    end
    irqEn_nxt = irqEn_r;
    if (busWr && adr_i == drs_pkg::OFF_IRQ_EN) begin
      irqEn_nxt = dat_i[7:0];
    end
    // power cause alone marks a power reset
    cause_nxt = cause_r;
    if (exitPulse && latch_r[drs_pkg::CB_POWER]) begin
      cause_nxt = 8'h00;
      cause_nxt[drs_pkg::CB_POWER] = 1'b1;
    end else if (exitPulse) begin
      // pin flag and the others from the latched causes, comparator enable bit kept
      cause_nxt = {1'b0, latch_r};
      cause_nxt[drs_pkg::CB_CMP] = cause_r[drs_pkg::CB_CMP];
    end else if (busWr && adr_i == drs_pkg::OFF_CAUSE) begin
      cause_nxt[drs_pkg::CB_CMP] = dat_i[drs_pkg::CB_CMP];
    end
    // Set wins over a clear in the same cycle
    irqStat_nxt = irqStat_r;
    if (busWr && adr_i == drs_pkg::OFF_IRQ_CLR) begin
      irqStat_nxt = irqStat_r & ~dat_i[7:0];
    end
    if (exitPulse) begin
      irqStat_nxt = irqStat_nxt | cause_nxt;
    end
    irq_nxt = |(irqStat_nxt & irqEn_nxt);
  end

  // hold and enable bits cleared only by power-on
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_r <= drs_pkg::CTRL_RST;
      irqEn_r <= drs_pkg::IRQ_EN_RST;
      irqStat_r <= drs_pkg::IRQ_STAT_RST;
      cause_r <= drs_pkg::CAUSE_RST;
      irq_r <= 1'b0;
      porInit_r <= 1'b1;
    end else begin
      ctrl_r <= ctrl_nxt;
      irqEn_r <= irqEn_nxt;
      irqStat_r <= irqStat_nxt;
      cause_r <= cause_nxt;
      irq_r <= irq_nxt;
      porInit_r <= 1'b0;
    end
  end

  // Power-on puts the sequencer straight into hold
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= drs_pkg::ST_HOLD;
      latch_r <= 7'h02;
      coreHalt_r <= 1'b1;
      pinOe_r <= 1'b1;
      stackLoad_r <= 1'b0;
      pcLoad_r <= 1'b0;
      pcValue_r <= drs_pkg::PC_RST;
      wdtEn_r <= 1'b0;
      clkInt_r <= 1'b1;
      port_r <= drs_pkg::PORT_LATCH_RST;
      portHold_r <= 1'b0;
      convHold_r <= 1'b0;
      portOd_r <= 1'b1;
      swReq_r <= 1'b0;
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else begin
      state_r <= state_nxt;
      latch_r <= latch_nxt;
      coreHalt_r <= coreHalt_nxt;
      pinOe_r <= pinOe_nxt;
      stackLoad_r <= stackLoad_nxt;
      pcLoad_r <= pcLoad_nxt;
      pcValue_r <= drs_pkg::PC_RST;
      wdtEn_r <= wdtEn_nxt;
      clkInt_r <= clkInt_nxt;
      port_r <= port_nxt;
      portHold_r <= portHold_nxt;
      convHold_r <= convHold_nxt;
      portOd_r <= portOd_nxt;
      swReq_r <= swReq_nxt;
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
    end
  end

  assign resetPinOut_n = 1'b0;
  assign resetPinOe = pinOe_r;
  assign dat_o = dat_r;
  assign ack_o = ack_r;
  assign coreHalt = coreHalt_r;
  assign sfrInit = coreHalt_r;
  assign porOnlyInit = porInit_r;
  // interrupts and timers off with the core
  assign irqTimersOff = coreHalt_r;
  assign stackPtrLoad = stackLoad_r;
  assign pcLoad = pcLoad_r;
  assign pcValue = pcValue_r;
  assign watchdogEnable = wdtEn_r;
  assign clockSelInternal = clkInt_r;
  assign portLatch = port_r;
  assign portOpenDrain = portOd_r;
  assign portWeakPullup = 1'b1;
  assign portStateHold = portHold_r;
  assign converterHold = convHold_r;
  assign irq = irq_r;

  sequence sExit;
    $fell(coreHalt_r);
  endsequence

  sequence sSoftWrite;
    swReq_r ##1 coreHalt_r;
  endsequence

  a_core_halt: assert property (@(posedge clk) disable iff (!rst_n)
    anySrc |=> coreHalt_r)
    else $error("core not halted after a reset source");
  a_sfr_init: assert property (@(posedge clk) disable iff (!rst_n)
    anySrc |=> sfrInit && !porOnlyInit)
    else $error("register init missing or power-only init wrong");
  a_irq_off: assert property (@(posedge clk) disable iff (!rst_n)
    anySrc |=> irqTimersOff)
    else $error("interrupts or timers active in reset");
  a_stack_load: assert property (@(posedge clk) disable iff (!rst_n)
    sExit |-> stackPtrLoad ##1 !stackPtrLoad)
    else $error("stack pointer not reloaded once at exit");
  a_port_ones: assert property (@(posedge clk) disable iff (!rst_n)
    coreHalt_r && !portHold_r |->
      portLatch == drs_pkg::PORT_LATCH_RST && portOpenDrain)
    else $error("port latches not all ones during reset");
  a_pin_drive: assert property (@(posedge clk) disable iff (!rst_n)
    supplyLow |=> resetPinOe && !resetPinOut_n)
    else $error("reset pin not driven for supply reset");
  a_pc_clear: assert property (@(posedge clk) disable iff (!rst_n)
    sExit |-> pcLoad && pcValue == drs_pkg::PC_RST)
    else $error("program counter not cleared at exit");
  a_wdt_on: assert property (@(posedge clk) disable iff (!rst_n)
    sExit |-> watchdogEnable && clockSelInternal)
    else $error("watchdog or clock select wrong at exit");
  a_pin_hold: assert property (@(posedge clk) disable iff (!rst_n)
    coreHalt_r && portHold_r |-> $stable(portLatch))
    else $error("held port state changed in reset");
  a_soft_flag: assert property (@(posedge clk) disable iff (!rst_n)
    sSoftWrite |-> ##[1:8] (!coreHalt_r && cause_r[drs_pkg::CB_SOFT]))
    else $error("software reset flag not set after exit");
  a_por_flag: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(porInit_r == 1'b0) |-> ##[1:8] cause_r == 8'h02)
    else $error("power flag not alone after power-on");
endmodule : drs_device_reset_sequencer

// file: tb/drs_pin_partner.sv
// External reset circuit model on the open-drain reset pin
module drs_pin_partner (
  input wire logic clk,
  input wire logic pressReq,
  input wire logic devOe,
  input wire logic devOut_n,
  output logic pinLevel_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic press_r;
  logic press_nxt;
  always_comb begin
    press_nxt = pressReq;
  end
  always_ff @(posedge clk) begin
    press_r <= press_nxt;
  end
  // Pull-up wins unless some party sinks the line
  assign pinLevel_n = !(press_r || (devOe && !devOut_n));
endmodule : drs_pin_partner

// file: tb/test_device_reset_sequencer.sv
// Self-checking bench for the device reset sequencer
module test_device_reset_sequencer;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_n, press, pinLevel_n, pinOut_n, pinOe, wdDis, clkExt;
  logic cyc, stb, we, ack, coreHalt, sfrInit, porInit, irqOff, spLoad;
  logic pcLoad, wdEn, clkInt, portOd, portPu, portHold, convHold, irq;
  logic [4:0] srcDrive;
  logic [4:0] adr;
  logic [3:0] sel;
  logic [7:0] portCore, portLatch;
  logic [15:0] pcValue;
  logic [31:0] datW, datR, rd;
  logic [7:0] causeTab [5] = '{8'h08, 8'h04, 8'h40, 8'h02, 8'h20};
  logic [4:0] oeMask = 5'h08;
  int err_total, check_count, n, pulses;

  drs_pin_partner pin_u (.clk(clk), .pressReq(press), .devOe(pinOe),
    .devOut_n(pinOut_n), .pinLevel_n(pinLevel_n));

  drs_device_reset_sequencer dut_u (.clk(clk), .rst_n(rst_n),
    .resetPinIn_n(pinLevel_n), .resetPinOut_n(pinOut_n),
    .resetPinOe(pinOe), .cmpTrip_n(!srcDrive[4]), .supplyLow(srcDrive[3]),
    .watchdogExpired(srcDrive[0]), .watchdogDisableReq(wdDis),
    .clockMissing(srcDrive[1]), .clockSelExternalReq(clkExt),
    .flashError(srcDrive[2]), .portLatchCore(portCore), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(datW),
    .dat_o(datR), .ack_o(ack), .coreHalt(coreHalt), .sfrInit(sfrInit),
    .porOnlyInit(porInit), .irqTimersOff(irqOff), .stackPtrLoad(spLoad),
    .pcLoad(pcLoad), .pcValue(pcValue), .watchdogEnable(wdEn),
    .clockSelInternal(clkInt), .portLatch(portLatch),
    .portOpenDrain(portOd), .portWeakPullup(portPu),
    .portStateHold(portHold), .converterHold(convHold), .irq(irq));

  task automatic chk(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic close_out();
    $display("Checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out

  task automatic give_up(input string what);
    err_total++;
    $display("[ERR] %s expected done seen timeout", what);
    close_out();
  endtask : give_up

  // Classic cycle held until ack is sampled high
  task automatic wb(input logic w, input logic [4:0] a,
      input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    datW <= d;
    sel <= 4'h1;
    for (n = 0; n < 20 && ack !== 1'b1; n++) @(posedge clk);
    if (n == 20) give_up("bus ack");
    rd = datR;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb

  task automatic rdchk(input logic [4:0] a, input logic [31:0] exp,
      input string what);
    wb(1'b0, a, 32'h0000_0000);
    chk(what, rd, exp);
  endtask : rdchk

  task automatic wait_halt();
    for (n = 0; n < 20 && coreHalt !== 1'b1; n++) @(posedge clk);
    if (n == 20) give_up("halt");
  endtask : wait_halt

  task automatic in_reset(input logic oe);
    chk("coreHalt", coreHalt, 1);
    chk("sfrInit", sfrInit, 1);
    chk("irqOff", irqOff, 1);
    chk("pinOe", pinOe, oe);
    chk("pinOut", pinOut_n, 0);
  endtask : in_reset

  // Exit must give exactly one load pulse
  task automatic wait_exit();
    pulses = 0;
    for (n = 0; n < 40 && coreHalt !== 1'b0; n++) begin
      @(posedge clk);
      if (pcLoad === 1'b1 && spLoad === 1'b1) pulses++;
    end
    if (n == 40) give_up("exit");
    repeat (3) begin
      @(posedge clk);
      if (pcLoad === 1'b1 && spLoad === 1'b1) pulses++;
    end
    chk("load pulses", 32'(pulses), 1);
    chk("pcValue", pcValue, 16'h0000);
    chk("wdEn", wdEn, 1);
    chk("clkInt", clkInt, 1);
    chk("irqOff", irqOff, 0);
    chk("pinOe", pinOe, 0);
  endtask : wait_exit

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    press = 1'b0;
    srcDrive = 5'h00;
    wdDis = 1'b0;
    clkExt = 1'b0;
    portCore = 8'h5A;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 5'h00;
    sel = 4'h0;
    datW = 32'h0000_0000;
    err_total = 0;
    check_count = 0;
    forever #50 clk = ~clk;
  end

  initial begin
    repeat (2) @(posedge clk);
    in_reset(1'b1);
    chk("portLatch", portLatch, 8'hFF);
    chk("portOd", portOd, 1);
    chk("portPu", portPu, 1);
    chk("porInit", porInit, 1);
    rst_n <= 1'b1;
    wait_exit();
    chk("porInit", porInit, 0);
    chk("portPu", portPu, 1);
    rdchk(drs_pkg::OFF_CAUSE, 32'h0000_0002, "cause");
    $display("Test power-on done");
    wdDis <= 1'b1;
    clkExt <= 1'b1;
    @(posedge clk);
    wdDis <= 1'b0;
    clkExt <= 1'b0;
    repeat (2) @(posedge clk);
    chk("wdEn", wdEn, 0);
    chk("clkInt", clkInt, 0);
    wb(1'b1, drs_pkg::OFF_CAUSE, 32'h0000_0010);
    wait_halt();
    in_reset(1'b0);
    wait_exit();
    rdchk(drs_pkg::OFF_CAUSE, 32'h0000_0010, "cause");
    $display("Test software done");
    for (int i = 0; i < 5; i++) begin
      if (i == 4) wb(1'b1, drs_pkg::OFF_CAUSE, 32'h0000_0020);
      @(posedge clk);
      srcDrive[i] <= 1'b1;
      wait_halt();
      in_reset(oeMask[i]);
      srcDrive[i] <= 1'b0;
      wait_exit();
      rdchk(drs_pkg::OFF_CAUSE, 32'(causeTab[i]), "cause");
    end
    $display("Test sources done");
    // Status holds watchdog and clock bits now
    wb(1'b1, drs_pkg::OFF_IRQ_EN, 32'h0000_0008);
    repeat (2) @(posedge clk);
    chk("irq", irq, 1);
    rdchk(drs_pkg::OFF_IRQ_EN, 32'h0000_0008, "irqEn");
    wb(1'b1, drs_pkg::OFF_IRQ_CLR, 32'h0000_0008);
    repeat (2) @(posedge clk);
    chk("irq", irq, 0);
    // Every exit so far, less the cleared watchdog bit
    rdchk(drs_pkg::OFF_IRQ_STAT, 32'h0000_0076, "irqStat");
    wb(1'b1, drs_pkg::OFF_IRQ_EN, 32'h0000_0004);
    repeat (2) @(posedge clk);
    chk("irq", irq, 1);
    wb(1'b1, drs_pkg::OFF_IRQ_EN, 32'h0000_0000);
    repeat (2) @(posedge clk);
    chk("irq", irq, 0);
    rdchk(5'h14, 32'h0000_0000, "unmapped");
    $display("Test interrupt done");
    wb(1'b1, drs_pkg::OFF_CTRL, 32'h0000_0003);
    rdchk(drs_pkg::OFF_CTRL, 32'h0000_0003, "ctrl");
    press <= 1'b1;
    wait_halt();
    in_reset(1'b0);
    chk("portHold", portHold, 1);
    chk("convHold", convHold, 1);
    chk("portLatch", portLatch, 8'h5A);
    chk("portOd", portOd, 0);
    press <= 1'b0;
    wait_exit();
    // Comparator enable survives non-power resets
    rdchk(drs_pkg::OFF_CAUSE, 32'h0000_0021, "cause");
    rdchk(drs_pkg::OFF_CTRL, 32'h0000_0003, "ctrl");
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk("portLatch", portLatch, 8'hFF);
    chk("portHold", portHold, 0);
    chk("convHold", convHold, 0);
    rst_n <= 1'b1;
    wait_exit();
    rdchk(drs_pkg::OFF_CTRL, 32'h0000_0000, "ctrl");
    rdchk(drs_pkg::OFF_CAUSE, 32'h0000_0002, "cause");
    $display("Test hold done");
    close_out();
  end
endmodule : test_device_reset_sequencer
